// File: design/svbl_pkg.sv
// Package for the loop band / lock status register bank.
// Assumes a plain register port with word indices 0x0B..0x11, byte address = 4 * index.
package svbl_pkg;
  localparam int          AW            = 8;
  localparam int          DW            = 32;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [7:0]  IDX_RSVD_A    = 8'h0B;
  localparam logic [7:0]  IDX_LOOP1_GR  = 8'h0C;
  localparam logic [7:0]  IDX_RSVD_B    = 8'h0D;
  localparam logic [7:0]  IDX_LOOP2_GR  = 8'h0E;
  localparam logic [7:0]  IDX_STATUS    = 8'h0F;
  localparam logic [7:0]  IDX_IRQ_STAT  = 8'h10;
  localparam logic [7:0]  IDX_IRQ_MASK  = 8'h11;
  localparam int          GR_BIT        = 31;
  localparam int          L2_LOCK_BIT   = 23;
  localparam int          L1_LOCK_BIT   = 21;
  localparam int          VAR_LSB       = 17;
  localparam logic        GR_RESET      = 1'b0;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
  localparam logic [1:0]  ZERO_IRQ      = 2'h0;
  // Interrupt status/mask layout: bit0 loop1 lock lost, bit1 loop2 lock lost
  localparam int          IRQ_L1        = 0;
  localparam int          IRQ_L2        = 1;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } svbl_bus_t;

  typedef struct packed {
    logic loop2Locked;
    logic loop1Locked;
  } svbl_lock_t;
endpackage : svbl_pkg

// File: design/svbl_regs.sv
// Loop band select and lock status register bank.
// Assumes synchronous lock-detector inputs, bus strobes of one cycle each.
`timescale 1ns/1ps
`default_nettype none
module svbl_regs #(
  parameter logic [31:0] FACTORY_A   = 32'h0000_0000,
  parameter logic [31:0] FACTORY_B   = 32'h0000_0000,
  parameter logic [30:0] FACTORY_GR1 = 31'h0000_0000,
  parameter logic [30:0] FACTORY_GR2 = 31'h0000_0000,
  // Arbitrary value, not tied to any real part
  parameter logic [1:0]  VARIANT     = 2'h2
) (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire svbl_pkg::svbl_bus_t     bus,
  input  wire svbl_pkg::svbl_lock_t    lockIn,
  output var  logic [31:0]             rdata,
  output var  logic                    loop1VcoGainRangeBit,
  output var  logic                    loop2VcoGainRangeBit,
  output var  logic                    irq
);
  logic [31:0] rsvdA_reg;
  logic [31:0] rsvdB_reg;
  logic [31:0] gr1_reg;
  logic [31:0] gr2_reg;
  logic [1:0]  lock_reg;
  logic [1:0]  irqStat_reg;
  logic [1:0]  irqMask_reg;
  logic [31:0] rdata_next;
  logic [1:0]  irqStat_next;
  logic [31:0] statusWord;
  logic [1:0]  lockLost;
  wire         selA    = bus.addr == svbl_pkg::IDX_RSVD_A;
  wire         selGr1  = bus.addr == svbl_pkg::IDX_LOOP1_GR;
  wire         selB    = bus.addr == svbl_pkg::IDX_RSVD_B;
  wire         selGr2  = bus.addr == svbl_pkg::IDX_LOOP2_GR;
  wire         selStat = bus.addr == svbl_pkg::IDX_STATUS;
  wire         selIst  = bus.addr == svbl_pkg::IDX_IRQ_STAT;
  wire         selImk  = bus.addr == svbl_pkg::IDX_IRQ_MASK;
  wire [1:0]   lockNow = {lockIn.loop2Locked, lockIn.loop1Locked};

  ////////////////////////////////////////////////////////////////////////////
  // Write enables, one per storage word; the status word has none
  wire         wrA     = bus.wr && selA;
  wire         wrB     = bus.wr && selB;
  wire         wrGr1   = bus.wr && selGr1;
  wire         wrGr2   = bus.wr && selGr2;
  wire         wrIst   = bus.wr && selIst;
  wire         wrImk   = bus.wr && selImk;

  ////////////////////////////////////////////////////////////////////////////
  // Status word is built from live detector levels
  always_comb
  begin
    statusWord = svbl_pkg::ZERO_WORD;
    statusWord[svbl_pkg::L2_LOCK_BIT] = lockIn.loop2Locked;
    statusWord[svbl_pkg::L1_LOCK_BIT] = lockIn.loop1Locked;
    statusWord[svbl_pkg::VAR_LSB +: 2] = VARIANT;
  end

  // Falling edge of a lock level is an event
  assign lockLost = lock_reg & ~lockNow;

  // Set beats the write-one clear in the same cycle
  assign irqStat_next = (irqStat_reg & ~(wrIst ? bus.wdata[1:0] : svbl_pkg::ZERO_IRQ))
                        | lockLost;

  // read returns live lock state, unknown index reads zero
  assign rdata_next = !bus.rd ? svbl_pkg::ZERO_WORD :
                      selA    ? rsvdA_reg :
                      selGr1  ? gr1_reg :
                      selB    ? rsvdB_reg :
                      selGr2  ? gr2_reg :
                      selStat ? statusWord :
                      selIst  ? {30'h0000_0000, irqStat_reg} :
                      selImk  ? {30'h0000_0000, irqMask_reg} :
                      svbl_pkg::ZERO_WORD;

  ////////////////////////////////////////////////////////////////////////////
  // Reserved words stay writable; host is trusted to write back what it read
  // reserved word A restores factory contents
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rsvdA_reg <= FACTORY_A;
    end
    else if (wrA)
    begin
      rsvdA_reg <= bus.wdata;
    end
  end

  // reserved word B restores factory contents
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rsvdB_reg <= FACTORY_B;
    end
    else if (wrB)
    begin
      rsvdB_reg <= bus.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // factory load of low bits; gain bit resets low
  // whole word stored, gain bit steers the loop
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      gr1_reg <= {svbl_pkg::GR_RESET, FACTORY_GR1};
    end
    else if (wrGr1)
    begin
      gr1_reg <= bus.wdata;
    end
  end

  // factory load of low bits; gain bit resets low
  // whole word stored, gain bit steers the loop
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      gr2_reg <= {svbl_pkg::GR_RESET, FACTORY_GR2};
    end
    else if (wrGr2)
    begin
      gr2_reg <= bus.wdata;
    end
  end

  // Output copy follows the write in the same edge so the loop sees no lag
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      loop1VcoGainRangeBit <= svbl_pkg::GR_RESET;
    end
    else
    begin
      loop1VcoGainRangeBit <= wrGr1 ? bus.wdata[svbl_pkg::GR_BIT]
                                    : gr1_reg[svbl_pkg::GR_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      loop2VcoGainRangeBit <= svbl_pkg::GR_RESET;
    end
    else
    begin
      loop2VcoGainRangeBit <= wrGr2 ? bus.wdata[svbl_pkg::GR_BIT]
                                    : gr2_reg[svbl_pkg::GR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock history resets to unlocked so release of reset makes no false loss
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lock_reg <= svbl_pkg::ZERO_IRQ;
    end
    else
    begin
      lock_reg <= lockNow;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irqStat_reg <= svbl_pkg::ZERO_IRQ;
    end
    else
    begin
      irqStat_reg <= irqStat_next;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irqMask_reg <= svbl_pkg::ZERO_IRQ;
    end
    else if (wrImk)
    begin
      irqMask_reg <= bus.wdata[1:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irqStat_next & irqMask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // no write path reaches the status word; reads stand one cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdata <= svbl_pkg::ZERO_WORD;
    end
    else
    begin
      rdata <= rdata_next;
    end
  end
endmodule : svbl_regs
`default_nettype wire

// File: tb/svbl_regs_props.sv
// Checker for the band and lock status register bank.
// Assumes svbl_pkg is compiled first; bound into svbl_regs.
`timescale 1ns/1ps
`default_nettype none
module svbl_regs_props #(
  parameter logic [1:0] VARIANT = 2'h2
) (
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire svbl_pkg::svbl_bus_t  bus,
  input wire svbl_pkg::svbl_lock_t lockIn,
  input wire logic [31:0]          rdata,
  input wire logic                 loop1VcoGainRangeBit,
  input wire logic                 loop2VcoGainRangeBit,
  input wire logic                 irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence stRd; bus.rd && bus.addr == svbl_pkg::IDX_STATUS; endsequence
  a_loop2_lock: assert property (stRd |=> rdata[23] == $past(lockIn.loop2Locked))
    else $error("loop2 lock bit wrong");
  a_loop1_lock: assert property (stRd |=> rdata[21] == $past(lockIn.loop1Locked))
    else $error("loop1 lock bit wrong");
  a_variant_code: assert property (stRd |=> rdata[18:17] == VARIANT)
    else $error("variant code wrong");
  a_lock_loss_seen: assert property (bus.rd && $fell(lockIn.loop1Locked) &&
    bus.addr == svbl_pkg::IDX_STATUS |=> !rdata[21])
    else $error("stale lock bit");
  a_status_ro: assert property (bus.wr && bus.addr == svbl_pkg::IDX_STATUS
    |=> $stable(loop1VcoGainRangeBit) && $stable(loop2VcoGainRangeBit))
    else $error("status write had effect");
  a_gain_update: assert property (bus.wr && bus.addr == svbl_pkg::IDX_LOOP1_GR
    |=> loop1VcoGainRangeBit == $past(bus.wdata[31]))
    else $error("loop1 gain bit not updated");
  a_read_idle: assert property (!bus.rd |=> rdata == 32'h0)
    else $error("read data not idle");
endmodule : svbl_regs_props
bind svbl_regs svbl_regs_props #(.VARIANT(VARIANT)) u_props (.mclk(mclk), .rst(rst),
  .bus(bus), .lockIn(lockIn), .rdata(rdata), .loop1VcoGainRangeBit(loop1VcoGainRangeBit),
  .loop2VcoGainRangeBit(loop2VcoGainRangeBit), .irq(irq));
`default_nettype wire

// File: tb/svbl_regs_tb_top.sv
// Bench for svbl_regs: register port tasks and lock stimulus.
// Assumes svbl_pkg and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module svbl_regs_tb_top;
  logic                 mclk = 0, rst = 1, irq, gain1, gain2;
  logic [31:0]          rdata;
  logic [1:0]           nl = 2'h3;
  svbl_pkg::svbl_bus_t  bus = '0;
  svbl_pkg::svbl_lock_t lockIn = 2'h3;
  int                   fails = 0, checksDone = 0;
  svbl_regs #(.FACTORY_A(32'hA5A5_1234), .FACTORY_GR1(31'h1234_5678), .FACTORY_GR2(31'h55))
    u_dut (.mclk(mclk), .rst(rst), .bus(bus), .lockIn(lockIn), .rdata(rdata),
    .loop1VcoGainRangeBit(gain1), .loop2VcoGainRangeBit(gain2), .irq(irq));
  initial forever #50 mclk = ~mclk;
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checksDone++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One strobe cycle; read data is settled just after the following edge
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{a, d, w, !w};
    lockIn <= nl;
    @(posedge mclk);
    bus <= '0;
    #1;
  endtask : acc
  task rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk("rdata", rdata, e);
  endtask : rd
  task tReset;
    rd(svbl_pkg::IDX_RSVD_A, 32'hA5A5_1234);
    rd(svbl_pkg::IDX_LOOP1_GR, {1'b0, 31'h1234_5678});
    rd(svbl_pkg::IDX_LOOP2_GR, 32'h55);
    chk("gain", {gain2, gain1}, 32'h0);
  endtask : tReset
  task tGain;
    logic [31:0] w;
    for (int i = 0; i < 2; i++)
    begin
      acc(1'b0, svbl_pkg::IDX_LOOP1_GR + 8'(2 * i), 32'h0);
      w = rdata | 32'h8000_0000;
      acc(1'b1, svbl_pkg::IDX_LOOP1_GR + 8'(2 * i), w);
      chk("gain", {gain2, gain1}, 32'(1 << i));
      rd(svbl_pkg::IDX_LOOP1_GR + 8'(2 * i), w);
      acc(1'b1, svbl_pkg::IDX_LOOP1_GR + 8'(2 * i), w & 32'h7FFF_FFFF);
      chk("gain", {gain2, gain1}, 32'h0);
    end
  endtask : tGain
  task tStatus;
    for (int c = 3; c >= 0; c--)
    begin
      nl = 2'(c);
      rd(svbl_pkg::IDX_STATUS, {8'h0, nl[1], 1'b0, nl[0], 4'h2, 17'h0});
    end
    acc(1'b1, svbl_pkg::IDX_STATUS, 32'hFFFF_FFFF);
    rd(svbl_pkg::IDX_STATUS, 32'h0004_0000);
    rd(8'h20, 32'h0);
  endtask : tStatus
  task tIrq;
    nl = 2'h3;
    acc(1'b1, svbl_pkg::IDX_IRQ_MASK, 32'h1);
    acc(1'b1, svbl_pkg::IDX_IRQ_STAT, 32'h3);
    rd(svbl_pkg::IDX_IRQ_STAT, 32'h0);
    chk("irq", irq, 32'h0);
    nl = 2'h2;
    acc(1'b0, svbl_pkg::IDX_IRQ_MASK, 32'h0);
    rd(svbl_pkg::IDX_IRQ_STAT, 32'h1);
    chk("irq", irq, 32'h1);
    nl = 2'h0;
    acc(1'b1, svbl_pkg::IDX_IRQ_STAT, 32'h1);
    rd(svbl_pkg::IDX_IRQ_STAT, 32'h2);
    chk("irq", irq, 32'h0);
    acc(1'b1, svbl_pkg::IDX_IRQ_MASK, 32'h3);
    rd(svbl_pkg::IDX_IRQ_MASK, 32'h3);
    chk("irq", irq, 32'h1);
  endtask : tIrq
  task conclude;
    if (fails == 0 && checksDone > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    tReset;
    tGain;
    tStatus;
    tIrq;
    conclude;
  end
endmodule : svbl_regs_tb_top
`default_nettype wire
